// File: rtl/staged_boot_runtime_watchdog.sv
// Boot-time and three-stage runtime watchdog with an APB register file.
// What this block does
// RULE1: Boot timeout disabled or 30s to 30min; the code lets boot code 7 expire at the first tick of self-test.
// RULE2: Boot watchdog counts in self-test, resets.
// RULE3: Boot watchdog halts during menu or password.
// RULE4: One-time mode disables after first event.
// RULE5: Single mode runs enabled stages once.
// RULE6: Repeated mode reruns last stage until reset.
// RULE7: Runtime disabled by default, armed before boot.
// RULE8: Optional start delay 10s to 30min.
// RULE9: Three stages; first issues selected event.
// RULE10: Stages two, three selectable or disabled.
// RULE11: Stage timeouts 1s to 30min each.
// RULE12: ACPI event means shutdown or restart.
// RULE13: Shutdown as overtemp, restart as fatal error.
// RULE14: No non-maskable interrupt action exists.
// RULE15: Software services; service restarts stage one.
// RULE16: Next enabled stage starts right after event; the code first times out a disabled stage two ahead of stage three.
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "wdt_regs.svh"

module staged_boot_runtime_watchdog #(
    parameter int TICK_CYCLES = `TICK_CYCLES
) (
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        nrst_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Boot phase status from firmware
    input  wire logic        post_active_i,
    input  wire logic        user_wait_i,
    // Actions
    output logic             sys_reset_o,
    output logic             pwr_button_o,
    output logic             overtemp_note_o,
    output logic             acpi_fatal_o,
    output logic             irq_o
);
    import wdt_pkg::*;

    // Seconds per selector code; code 0 stands for disabled where allowed.
    function automatic logic [10:0] boot_sec(input logic [2:0] c); // RULE1
        case (c)
            3'h1: boot_sec = 11'd30;
            3'h2: boot_sec = 11'd60;
            3'h3: boot_sec = 11'd120;
            3'h4: boot_sec = 11'd300;
            3'h5: boot_sec = 11'd600;
            3'h6: boot_sec = 11'd1800;
            default: boot_sec = 11'd0;
        endcase
    endfunction
    function automatic logic [10:0] delay_sec(input logic [2:0] c); // RULE8
        case (c)
            3'h1: delay_sec = 11'd10;
            3'h2: delay_sec = 11'd30;
            3'h3: delay_sec = 11'd60;
            3'h4: delay_sec = 11'd120;
            3'h5: delay_sec = 11'd300;
            3'h6: delay_sec = 11'd600;
            3'h7: delay_sec = 11'd1800;
            default: delay_sec = 11'd0;
        endcase
    endfunction
    function automatic logic [10:0] stage_sec(input logic [3:0] c); // RULE11
        case (c)
            4'h0: stage_sec = 11'd1;
            4'h1: stage_sec = 11'd2;
            4'h2: stage_sec = 11'd5;
            4'h3: stage_sec = 11'd10;
            4'h4: stage_sec = 11'd30;
            4'h5: stage_sec = 11'd60;
            4'h6: stage_sec = 11'd120;
            4'h7: stage_sec = 11'd300;
            4'h8: stage_sec = 11'd600;
            default: stage_sec = 11'd1800;
        endcase
    endfunction

    // Configuration registers.
    logic [31:0] boot_cfg_r;
    logic [31:0] run_cfg_r;
    logic [31:0] stage_cfg_r;
    logic [2:0]  irq_stat_r;
    logic [2:0]  irq_en_r;

    // Boot config: [2:0] timeout code, [4] halt on user interaction.
    wire  [2:0]  boot_code   = boot_cfg_r[2:0];
    wire         halt_user   = boot_cfg_r[4];
    // Run config: [1:0] mode, [6:4] delay code, [8] ACPI restart.
    wire run_mode_t run_mode = run_mode_t'(run_cfg_r[1:0]);
    wire  [2:0]  delay_code  = run_cfg_r[6:4];
    wire         acpi_restart = run_cfg_r[8];

    // APB decode.
    wire         acc   = psel_i & penable_i;
    wire         wr    = acc & pwrite_i;
    wire         hit_boot  = paddr_i == `OFF_BOOT_CFG;
    wire         hit_run   = paddr_i == `OFF_RUN_CFG;
    wire         hit_stage = paddr_i == `OFF_STAGE_CFG;
    wire         hit_ctrl  = paddr_i == `OFF_CONTROL;
    wire         hit_stat  = paddr_i == `OFF_STATUS;
    wire         hit_ist   = paddr_i == `OFF_IRQ_STATUS;
    wire         hit_ien   = paddr_i == `OFF_IRQ_ENABLE;
    wire         hit_iclr  = paddr_i == `OFF_IRQ_CLEAR;
    wire         mapped = hit_boot | hit_run | hit_stage | hit_ctrl |
                          hit_stat | hit_ist | hit_ien | hit_iclr;
    // Control: bit0 arms runtime watchdog, bit1 services it.
    wire         arm_w     = wr & hit_ctrl & pwdata_i[0];
    wire         service_w = wr & hit_ctrl & pwdata_i[1];

    assign pready_o  = 1'b1;
    assign pslverr_o = acc & ~mapped;

    // Seconds prescaler shared by both watchdogs. It runs freely, so a
    // count that starts between ticks may end up to one second early.
    logic [31:0] pre_r;
    wire         tick = pre_r == 32'(TICK_CYCLES - 1);
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i || tick) pre_r <= '0;
        else                 pre_r <= pre_r + 32'h1;
    end

    // Boot watchdog.
    logic [10:0] boot_cnt_r;
    logic        boot_fired_r;
    // A halt freezes the count instead of clearing it, so a long menu
    // visit does not hand the boot a fresh budget.
    wire         boot_halt = halt_user & user_wait_i; // RULE3
    wire         boot_run  = (boot_code != 3'h0) && post_active_i &&
                             !boot_fired_r; // RULE2
    wire         boot_exp  = boot_run && !boot_halt && tick &&
                             (boot_cnt_r + 11'h1 >= boot_sec(boot_code));
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i || !post_active_i)
        begin
            boot_cnt_r   <= '0;
            boot_fired_r <= 1'b0;
        end
        else if (boot_exp)
            boot_fired_r <= 1'b1; // RULE2
        else if (boot_run && !boot_halt && tick)
            boot_cnt_r <= boot_cnt_r + 11'h1;
    end

    // Runtime watchdog; stage cfg: [3:0]/[7:4]/[11:8] timeout codes,
    // [17:16]/[19:18]/[21:20] events per stage.
    run_state_t  rs_r;
    logic [1:0]  stage_r;
    logic [10:0] rcnt_r;
    wire  [3:0]  tcode  = stage_cfg_r[stage_r*4 +: 4];
    wire  event_t cur_ev = event_t'(stage_cfg_r[16 + stage_r*2 +: 2]);
    wire  event_t ev2    = event_t'(stage_cfg_r[19:18]);
    wire  event_t ev3    = event_t'(stage_cfg_r[21:20]);
    // Stage 1 always acts; a disabled code there means ACPI.
    wire  event_t fire_ev = (stage_r == 2'd0 && cur_ev == EV_OFF) ?
                            EV_ACPI : cur_ev; // RULE9
    // A disabled stage two ahead of an enabled stage three still times
    // out with no action, setting only irq status [1], before stage three starts.
    wire  [1:0]  last_stage = (ev3 != EV_OFF) ? 2'd2 :
                              (ev2 != EV_OFF) ? 2'd1 : 2'd0; // RULE10
    wire         delay_done = rcnt_r + 11'h1 >= delay_sec(delay_code);
    wire         stage_exp  = rs_r == ST_RUN && tick &&
                              rcnt_r + 11'h1 >= stage_sec(tcode);
    // A service in the expiry cycle wins, so a just-in-time service
    // never triggers an action.
    wire         run_fire   = stage_exp && !service_w;

    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            rs_r    <= ST_IDLE; // RULE7
            stage_r <= 2'd0;
            rcnt_r  <= '0;
        end
        else
        begin
            unique case (rs_r)
                // Arming is heard only while stopped, so a stray write
                // cannot restart a running sequence.
                ST_IDLE, ST_DONE:
                    if (arm_w && run_mode != RM_OFF)
                    begin
                        rcnt_r  <= '0;
                        stage_r <= 2'd0;
                        rs_r    <= (delay_code != 3'h0) ? ST_DELAY
                                                        : ST_RUN; // RULE8
                    end
                ST_DELAY:
                    if (tick)
                    begin
                        rcnt_r <= delay_done ? 11'h0 : rcnt_r + 11'h1;
                        if (delay_done) rs_r <= ST_RUN;
                    end
                ST_RUN:
                    if (service_w)
                    begin
                        rcnt_r  <= '0; // RULE15
                        stage_r <= 2'd0;
                    end
                    else if (stage_exp)
                    begin
                        rcnt_r <= '0;
                        if (run_mode == RM_ONE)
                            rs_r <= ST_DONE; // RULE4
                        else if (stage_r != last_stage)
                            stage_r <= stage_r + 2'd1; // RULE16
                        else if (run_mode == RM_SINGLE)
                            rs_r <= ST_DONE; // RULE5
                        // Repeated mode stays on the last stage.
                    end // RULE6
                    else if (tick)
                        rcnt_r <= rcnt_r + 11'h1;
            endcase
        end
    end

    // Action pulses; only ACPI, reset and power button exist.
    logic        sys_reset_r;
    logic        pwr_button_r;
    logic        overtemp_r;
    logic        fatal_r;
    wire         acpi_fire = run_fire && fire_ev == EV_ACPI; // RULE14
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            sys_reset_r  <= 1'b0;
            pwr_button_r <= 1'b0;
            overtemp_r   <= 1'b0;
            fatal_r      <= 1'b0;
        end
        else
        begin
            sys_reset_r  <= boot_exp ||
                            (run_fire && fire_ev == EV_RESET);
            pwr_button_r <= run_fire && fire_ev == EV_PWRBTN;
            overtemp_r   <= acpi_fire && !acpi_restart; // RULE12 RULE13
            fatal_r      <= acpi_fire && acpi_restart; // RULE12 RULE13
        end
    end
    assign sys_reset_o     = sys_reset_r;
    assign pwr_button_o    = pwr_button_r;
    assign overtemp_note_o = overtemp_r;
    assign acpi_fatal_o    = fatal_r;

    // Interrupt events: [0] boot expiry, [1] runtime stage event,
    // [2] runtime watchdog finished. Set wins over clear.
    wire  [2:0]  ev_set = {run_fire &&
                           (run_mode == RM_ONE ||
                            (run_mode == RM_SINGLE &&
                             stage_r == last_stage)),
                           run_fire, boot_exp};
    wire  [2:0]  clr    = (wr && hit_iclr) ? pwdata_i[2:0] : 3'h0;
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            boot_cfg_r  <= `BOOT_CFG_RST;
            run_cfg_r   <= `RUN_CFG_RST;
            stage_cfg_r <= `STAGE_CFG_RST;
            irq_en_r    <= 3'h0;
            irq_stat_r  <= 3'h0;
        end
        else
        begin
            if (wr && hit_boot)  boot_cfg_r  <= pwdata_i & `BOOT_CFG_MASK;
            if (wr && hit_run)   run_cfg_r   <= pwdata_i & `RUN_CFG_MASK;
            if (wr && hit_stage) stage_cfg_r <= pwdata_i & `STAGE_CFG_MASK;
            if (wr && hit_ien)   irq_en_r    <= pwdata_i[2:0];
            irq_stat_r <= (irq_stat_r & ~clr) | ev_set;
        end
    end
    assign irq_o = |(irq_stat_r & irq_en_r);

    // Read data selection.
    wire  [31:0] status_w = {20'h0, rcnt_r[10:0] == 11'h0 ? 1'b0 : 1'b1,
                             boot_fired_r, stage_r, 6'h0, rs_r};
    wire  [31:0] rd_mux =
        hit_boot  ? boot_cfg_r  :
        hit_run   ? run_cfg_r   :
        hit_stage ? stage_cfg_r :
        hit_stat  ? status_w    :
        hit_ist   ? {29'h0, irq_stat_r} :
        hit_ien   ? {29'h0, irq_en_r} : 32'h0;
    // Read data is captured in the setup cycle and shown during the
    // access phase, so it comes from a flip-flop with no wait state.
    logic [31:0] prdata_r;
    wire         rd_setup = psel_i & ~penable_i & ~pwrite_i;
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i) prdata_r <= 32'h0;
        else         prdata_r <= rd_setup ? rd_mux : 32'h0;
    end
    assign prdata_o = prdata_r;

endmodule // staged_boot_runtime_watchdog

// File: rtl/wdt_regs.svh
// Register offsets, reset values, write masks and timing counts.
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH

`define OFF_BOOT_CFG    12'h000
`define OFF_RUN_CFG     12'h004
`define OFF_STAGE_CFG   12'h008
`define OFF_CONTROL     12'h00c
`define OFF_STATUS      12'h010
`define OFF_IRQ_STATUS  12'h014
`define OFF_IRQ_ENABLE  12'h018
`define OFF_IRQ_CLEAR   12'h01c

`define BOOT_CFG_RST    32'h0000_0010
`define RUN_CFG_RST     32'h0000_0000
`define STAGE_CFG_RST   32'h0000_0000

`define BOOT_CFG_MASK   32'h0000_0017
`define RUN_CFG_MASK    32'h0000_0173
`define STAGE_CFG_MASK  32'h003f_0fff

`define CLK_HZ          25000000
`define TICK_CYCLES     (`CLK_HZ)
`endif

// File: rtl/wdt_pkg.sv
// Types shared by the watchdog.
package wdt_pkg;
    typedef enum logic [1:0] {RM_OFF, RM_ONE, RM_SINGLE, RM_REPEAT} run_mode_t;
    typedef enum logic [1:0] {EV_OFF, EV_ACPI, EV_RESET, EV_PWRBTN} event_t;
    typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_RUN, ST_DONE} run_state_t;
endpackage

// File: verif/wdt_properties.sv
// Port assertions for the staged watchdog.
`timescale 1ns/1ps
module wdt_properties #(parameter int TICK_CYCLES = 4) (
    // Clock, reset and APB
    input wire logic        core_clk_i,
    input wire logic        nrst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    // Actions and interrupt
    input wire logic        sys_reset_o,
    input wire logic        pwr_button_o,
    input wire logic        overtemp_note_o,
    input wire logic        acpi_fatal_o,
    input wire logic        irq_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!nrst_i);
    sequence acc_s;
        psel_i && penable_i;
    endsequence
    ready_high_a: assert property (pready_o) else $error("pready low");
    idle_data_a: assert property (!(psel_i && penable_i) |-> prdata_o == 0)
        else $error("prdata not zero");
    bad_addr_a: assert property (acc_s ##0 (paddr_i > 12'h01c) |-> pslverr_o)
        else $error("no slave error");
    acpi_excl_a: assert property (!(overtemp_note_o && acpi_fatal_o))
        else $error("two acpi requests");
    reset_pulse_a: assert property (sys_reset_o |=> !sys_reset_o)
        else $error("reset pulse too long");
    button_gap_a: assert property (pwr_button_o |=> !pwr_button_o[*2])
        else $error("button pulses too close");
    irq_drop_a: assert property
        ($fell(irq_o) |-> $past(psel_i && penable_i && pwrite_i))
        else $error("irq dropped without a write");
    quiet_start_a: assert property
        ($rose(nrst_i) |-> !(sys_reset_o || pwr_button_o || irq_o))
        else $error("action right after reset");
endmodule // wdt_properties

bind staged_boot_runtime_watchdog wdt_properties #(.TICK_CYCLES(TICK_CYCLES))
    u_props (.core_clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .prdata_o, .pready_o, .pslverr_o, .sys_reset_o, .pwr_button_o,
    .overtemp_note_o, .acpi_fatal_o, .irq_o);

// File: verif/host_boot_model.sv
// Host model driving the self-test and user-wait levels.
`timescale 1ns/1ps
module host_boot_model (
    // Requests from the bench
    input  wire logic core_clk_i,
    input  wire logic post_req_i,
    input  wire logic menu_req_i,
    // Levels seen by the watchdog
    output logic      post_active_o = 1'b0,
    output logic      user_wait_o = 1'b0
);
    // A menu can only be up during self-test, so it is gated by it.
    always_ff @(posedge core_clk_i)
    begin
        post_active_o <= post_req_i;
        user_wait_o   <= menu_req_i & post_req_i;
    end
endmodule // host_boot_model

// File: verif/staged_boot_runtime_watchdog_test.sv
// Self-checking bench for the staged watchdog.
`timescale 1ns/1ps
`include "wdt_regs.svh"
module staged_boot_runtime_watchdog_test;
    logic        core_clk_i = 1'b0, nrst_i = 1'b0, post_req = 1'b0;
    logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic        menu_req = 1'b0, pready_o, pslverr_o, err, irq_o;
    logic        post_active_i, user_wait_i, sys_reset_o, pwr_button_o;
    logic        overtemp_note_o, acpi_fatal_o;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic [3:0]  act;
    int          error_cnt = 0, n_checks = 0, n;
    logic [31:0] run_t [3] = '{32'h1, 32'h102, 32'h3};
    logic [31:0] stg_t [3] = '{32'h90000, 32'h390000, 32'he0000};
    logic [15:0] exp_t [3] = '{16'h2000, 16'h1840, 16'h8444};
    always #20 core_clk_i = ~core_clk_i;
    staged_boot_runtime_watchdog #(.TICK_CYCLES(4)) u_dut (.core_clk_i,
        .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .prdata_o, .pready_o, .pslverr_o, .post_active_i, .user_wait_i,
        .sys_reset_o, .pwr_button_o, .overtemp_note_o, .acpi_fatal_o, .irq_o);
    host_boot_model u_host (.core_clk_i, .post_req_i(post_req),
        .menu_req_i(menu_req), .post_active_o(post_active_i),
        .user_wait_o(user_wait_i));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge core_clk_i);
        {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, d};
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        do
            @(posedge core_clk_i);
        while (pready_o !== 1'b1);
        {rd, err} = {prdata_o, pslverr_o};
        {psel_i, penable_i} <= 2'b00;
    endtask
    // Pulses are registered, so they are sampled just after the edge.
    task automatic wait_act(input int lim);
        {n, act} = '0;
        while (act === 4'h0 && n < lim)
        begin
            @(posedge core_clk_i);
            #1 act = {sys_reset_o, pwr_button_o, overtemp_note_o,
                      acpi_fatal_o};
            n++;
        end
    endtask
    task automatic reset_dut;
        nrst_i <= 1'b0;
        repeat (20) @(posedge core_clk_i);
        nrst_i <= 1'b1;
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        #200000 error_cnt++;
        wrap_up();
    end
    initial
    begin
        reset_dut();
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b0, 12'(4 * i), 32'h0);
            check(rd, (i == 0) ? `BOOT_CFG_RST : 32'h0);
        end
        apb(1'b0, 12'h020, 32'h0);
        check({err, rd[30:0]}, 32'h8000_0000);
        apb(1'b1, `OFF_IRQ_ENABLE, 32'h7);
        apb(1'b1, `OFF_BOOT_CFG, 32'h11);
        post_req <= 1'b1;
        repeat (20) @(posedge core_clk_i);
        menu_req <= 1'b1;
        repeat (120) @(posedge core_clk_i);
        menu_req <= 1'b0;
        wait_act(200);
        post_req <= 1'b0;
        check(act, 4'h8);
        check({31'h0, n inside {[96:106]}}, 32'h1);
        check({31'h0, irq_o}, 32'h1);
        apb(1'b0, `OFF_IRQ_STATUS, 32'h0);
        check(rd, 32'h1);
        apb(1'b1, `OFF_IRQ_ENABLE, 32'h0);
        #1 check({31'h0, irq_o}, 32'h0);
        apb(1'b1, `OFF_IRQ_CLEAR, 32'h7);
        apb(1'b0, `OFF_IRQ_STATUS, 32'h0);
        check(rd, 32'h0);
        for (int m = 0; m < 3; m++)
        begin
            reset_dut();
            apb(1'b1, `OFF_STAGE_CFG, stg_t[m]);
            apb(1'b1, `OFF_RUN_CFG, run_t[m]);
            apb(1'b1, `OFF_CONTROL, 32'h1);
            for (int k = 0; k < 4; k++)
            begin
                wait_act(40);
                check(act, exp_t[m][12-4*k +: 4]);
                if (k > 0 && act !== 4'h0)
                    check(n, 4);
            end
            apb(1'b0, `OFF_STATUS, 32'h0);
            check(rd[1:0], (m == 2) ? 2'd2 : 2'd3);
        end
        reset_dut();
        apb(1'b1, `OFF_STAGE_CFG, 32'h20001);
        apb(1'b1, `OFF_RUN_CFG, 32'h11);
        apb(1'b1, `OFF_CONTROL, 32'h1);
        wait_act(36);
        check(act, 4'h0);
        repeat (10) apb(1'b1, `OFF_CONTROL, 32'h2);
        wait_act(8);
        check(act, 4'h8);
        wrap_up();
    end
endmodule // staged_boot_runtime_watchdog_test
